// ### hdl/spcc_pkg.sv
// Package for the socket power and clock control register bank.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package spcc_pkg;
	localparam logic [11:0] SPCC_SOCKET_CONTROL_OFS = 12'h010;
	localparam logic [11:0] SPCC_SOCKET_STATUS_OFS = 12'h014;
	localparam logic [11:0] SPCC_RETEST_OFS = 12'h018;
	localparam logic [31:0] SPCC_SOCKET_CONTROL_RST = 32'h00000000;
	localparam int SPCC_STOP_POLICY_BIT = 7;
	localparam int SPCC_CARD_REQ_LSB = 4;
	localparam int SPCC_PROG_REQ_LSB = 0;
	localparam int SPCC_REQ_W = 3;
	localparam int SPCC_RETEST_BIT = 14;
	localparam logic [3:0] SPCC_IDLE_CLOCKS = 4'h8;
	localparam logic [2:0] SPCC_REQ_OFF = 3'h0;
	localparam logic [2:0] SPCC_REQ_12V = 3'h1;
	localparam logic [2:0] SPCC_REQ_5V = 3'h2;
	localparam logic [2:0] SPCC_REQ_3V3 = 3'h3;
	localparam logic [2:0] SPCC_REQ_XX = 3'h4;
	localparam logic [2:0] SPCC_REQ_YY = 3'h5;
	// Acceptable voltage set, one bit per code above: {YY, XX, 3V3, 5V}.
	localparam int SPCC_ACCEPT_W = 4;
	typedef enum logic [1:0] {SPCC_RUN, SPCC_STOP_REQ} spcc_clk_e;
endpackage

// ### hdl/spcc_supply_gate.sv
// Turns one written supply request into the applied supply code.
// Assumes the acceptable-voltage mask is stable in the host clock domain.
`timescale 1ns/1ps
module spcc_supply_gate
	import spcc_pkg::*;
#(
	parameter bit ALLOW_12V = 1'b0
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [SPCC_REQ_W-1:0] request,
	input wire logic [SPCC_ACCEPT_W-1:0] accept,
	input wire logic enable,
	output logic [SPCC_REQ_W-1:0] applied
);
	logic [SPCC_REQ_W-1:0] applied_r;
	logic [SPCC_REQ_W-1:0] applied_nxt;
	wire is_off = request == SPCC_REQ_OFF;
	wire is_12v = ALLOW_12V && request == SPCC_REQ_12V;
	wire in_set = request >= SPCC_REQ_5V && request <= SPCC_REQ_YY;
	wire [1:0] set_idx = 2'(request - SPCC_REQ_5V);
	wire acceptable = is_off || is_12v || (in_set && accept[set_idx]);
	// Power off is always honoured, even while control is disabled, for safety.
	wire take = load && (is_off || (acceptable && enable));
	assign applied_nxt = take ? request : applied_r;
	assign applied = applied_r;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			applied_r <= SPCC_REQ_OFF;
		else
			applied_r <= applied_nxt;
	end
endmodule

// ### hdl/spcc_top.sv
// Socket control register bank: supply requests and card clock stop policy.
// Assumes an APB master on CLK; card status arrives from pins.
// What this block does
// - Socket control at 10h, resets to zero.
// - Bits 31 to 8 read zero, ignore writes.
// - Bit 3 always reads zero.
// - Policy zero: stop needs idle and host request.
// - Policy one: stop after eight idle clocks.
// - Card supply field bits 6 to 4.
// - Programming supply field bits 2 to 0.
// - Apply only voltages the card accepts; programming supply also takes 12V.
// - Retest reinterrogates and re-enables power control.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module spcc_top
	import spcc_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic CARD_BUS_IDLE,
	input wire logic HOST_CLOCK_STOP_REQ,
	input wire logic [SPCC_ACCEPT_W-1:0] CARD_ACCEPT_VOLTAGES,
	input wire logic FORCE_DISABLE,
	output logic CARD_CLOCK_STOP_REQ,
	output logic [SPCC_REQ_W-1:0] CARD_SUPPLY,
	output logic [SPCC_REQ_W-1:0] PROGRAMMING_SUPPLY,
	output logic RETEST_PULSE
);
	logic [1:0] rst_sync_r;
	wire rst_n = rst_sync_r[1];
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end

	// Idle, host and voltage pins pass three flops; a change counts when stages two and three agree.
	logic [2:0] idle_s_r;
	logic [2:0] host_s_r;
	logic [SPCC_ACCEPT_W-1:0] acc_s1_r;
	logic [SPCC_ACCEPT_W-1:0] acc_s2_r;
	logic [SPCC_ACCEPT_W-1:0] acc_s3_r;
	logic idle_q_r;
	logic host_q_r;
	logic [SPCC_ACCEPT_W-1:0] acc_q_r;
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			idle_s_r <= 3'h0;
			idle_q_r <= 1'b0;
		end
		else
		begin
			idle_s_r <= {idle_s_r[1:0], CARD_BUS_IDLE};
			if (idle_s_r[1] == idle_s_r[2])
				idle_q_r <= idle_s_r[2];
		end
	end

	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			host_s_r <= 3'h0;
			host_q_r <= 1'b0;
		end
		else
		begin
			host_s_r <= {host_s_r[1:0], HOST_CLOCK_STOP_REQ};
			if (host_s_r[1] == host_s_r[2])
				host_q_r <= host_s_r[2];
		end
	end

	// The whole mask must agree across two stages, so a word caught mid-change is never taken.
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_s1_r <= '0;
			acc_s2_r <= '0;
			acc_s3_r <= '0;
			acc_q_r <= '0;
		end
		else
		begin
			acc_s1_r <= CARD_ACCEPT_VOLTAGES;
			acc_s2_r <= acc_s1_r;
			acc_s3_r <= acc_s2_r;
			if (acc_s2_r == acc_s3_r)
				acc_q_r <= acc_s3_r;
		end
	end

	// APB decode; zero wait states, every access completes in its access phase.
	wire access = PSEL && PENABLE;
	wire wr = access && PWRITE;
	wire hit_ctl = PADDR == SPCC_SOCKET_CONTROL_OFS;
	wire hit_sts = PADDR == SPCC_SOCKET_STATUS_OFS;
	wire hit_rt = PADDR == SPCC_RETEST_OFS;
	wire mapped = hit_ctl || hit_sts || hit_rt;
	assign PREADY = 1'b1;
	assign PSLVERR = access && !mapped;

	logic stop_policy_r;
	logic [SPCC_REQ_W-1:0] card_req_r;
	logic [SPCC_REQ_W-1:0] prog_req_r;
	logic ctl_enable_r;
	wire ctl_wr = wr && hit_ctl;
	wire [SPCC_REQ_W-1:0] card_wd = PWDATA[SPCC_CARD_REQ_LSB +: SPCC_REQ_W];
	wire [SPCC_REQ_W-1:0] prog_wd = PWDATA[SPCC_PROG_REQ_LSB +: SPCC_REQ_W];
	wire rt_wr = wr && hit_rt && PWDATA[SPCC_RETEST_BIT];
	// Reserved codes are stored as written; only the gates decide what reaches the pins.
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stop_policy_r <= SPCC_SOCKET_CONTROL_RST[SPCC_STOP_POLICY_BIT];
			card_req_r <= SPCC_REQ_OFF;
			prog_req_r <= SPCC_REQ_OFF;
		end
		else if (ctl_wr)
		begin
			stop_policy_r <= PWDATA[SPCC_STOP_POLICY_BIT];
			card_req_r <= card_wd;
			prog_req_r <= prog_wd;
		end
	end

	// Retest wins over a forced disable arriving in the same cycle.
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
			ctl_enable_r <= 1'b1;
		else if (rt_wr)
			ctl_enable_r <= 1'b1;
		else if (FORCE_DISABLE)
			ctl_enable_r <= 1'b0;
	end

	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
			RETEST_PULSE <= 1'b0;
		else
			RETEST_PULSE <= rt_wr;
	end

	spcc_supply_gate #(.ALLOW_12V(1'b0)) u_card_gate (
		.clk(CLK),
		.rst_n(rst_n),
		.load(ctl_wr),
		.request(card_wd),
		.accept(acc_q_r),
		.enable(ctl_enable_r),
		.applied(CARD_SUPPLY)
	);
	spcc_supply_gate #(.ALLOW_12V(1'b1)) u_prog_gate (
		.clk(CLK),
		.rst_n(rst_n),
		.load(ctl_wr),
		.request(prog_wd),
		.accept(acc_q_r),
		.enable(ctl_enable_r),
		.applied(PROGRAMMING_SUPPLY)
	);

	// Idle counter saturates at eight so a long idle keeps the request asserted.
	logic [3:0] idle_cnt_r;
	spcc_clk_e clk_state_r;
	wire idle_enough = idle_cnt_r == SPCC_IDLE_CLOCKS;
	wire stop_cond = idle_enough && (stop_policy_r || host_q_r);
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			idle_cnt_r <= 4'h0;
			clk_state_r <= SPCC_RUN;
		end
		else
		begin
			if (!idle_q_r)
				idle_cnt_r <= 4'h0;
			else if (!idle_enough)
				idle_cnt_r <= idle_cnt_r + 4'h1;
			case (clk_state_r)
				SPCC_RUN:
					if (stop_cond)
						clk_state_r <= SPCC_STOP_REQ;
				SPCC_STOP_REQ:
					if (!stop_cond)
						clk_state_r <= SPCC_RUN;
				default:
					clk_state_r <= SPCC_RUN;
			endcase
		end
	end
	assign CARD_CLOCK_STOP_REQ = clk_state_r == SPCC_STOP_REQ;

	// Reserved bits are built as zeros, so writes to them cannot stick.
	wire [31:0] ctl_rd = {24'h000000, stop_policy_r, card_req_r, 1'b0, prog_req_r};
	wire [31:0] sts_rd = {20'h00000, ctl_enable_r, acc_q_r, CARD_SUPPLY, 1'b0,
		PROGRAMMING_SUPPLY};
	// Read data is captured in the setup phase, so PRDATA comes from a flop with no wait state.
	logic [31:0] prdata_r;
	wire rd_setup = PSEL && !PENABLE && !PWRITE;
	wire [31:0] rd_sel = hit_ctl ? ctl_rd :
		hit_sts ? sts_rd : 32'h00000000;
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
			prdata_r <= 32'h00000000;
		else if (rd_setup)
			prdata_r <= rd_sel;
		else
			prdata_r <= 32'h00000000;
	end
	assign PRDATA = prdata_r;
endmodule

// ### dv/spcc_card.sv
// Card side model: idle indication and accepted voltages, one flop late.
// Assumes the bench steers it from the host clock domain.
`timescale 1ns/1ps
module spcc_card
(
	input wire logic clk,
	input wire logic quiet,
	input wire logic [3:0] volts,
	output logic idle = 1'b0,
	output logic [3:0] acc = 4'h0
);
	always @(posedge clk)
	begin
		idle <= quiet;
		acc <= volts;
	end
endmodule

// ### dv/spcc_monitor.sv
// Port checker for the socket control bank.
// Assumes zero-wait APB and the synchroniser delay on the idle input.
`timescale 1ns/1ps
module spcc_monitor
	import spcc_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic CARD_BUS_IDLE,
	input wire logic CARD_CLOCK_STOP_REQ,
	input wire logic [SPCC_REQ_W-1:0] CARD_SUPPLY,
	input wire logic [SPCC_REQ_W-1:0] PROGRAMMING_SUPPLY,
	input wire logic RETEST_PULSE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	wire acc = PSEL && PENABLE;
	wire rd = acc && !PWRITE && PADDR == SPCC_SOCKET_CONTROL_OFS;
	wire wr = acc && PWRITE && PADDR == SPCC_SOCKET_CONTROL_OFS;
	wire rt = acc && PWRITE && PADDR == SPCC_RETEST_OFS;
	property p_hi; rd |-> PRDATA[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper bits set");
	property p_b3; rd |-> !PRDATA[3]; endproperty
	a_b3: assert property (p_b3) else $error("bit three set");
	// The stop request lags the idle pin through the synchroniser.
	property p_stp; CARD_CLOCK_STOP_REQ |-> $past(CARD_BUS_IDLE, 8); endproperty
	a_stp: assert property (p_stp) else $error("stop without idle");
	property p_vcc; CARD_SUPPLY inside {3'h0, [3'h2:3'h5]}; endproperty
	a_vcc: assert property (p_vcc) else $error("bad card supply");
	property p_vpp; PROGRAMMING_SUPPLY <= 3'h5; endproperty
	a_vpp: assert property (p_vpp) else $error("bad prog supply");
	property p_chg;
		$changed(CARD_SUPPLY) || $changed(PROGRAMMING_SUPPLY) |-> $past(wr);
	endproperty
	a_chg: assert property (p_chg) else $error("supply moved");
	property p_rt; RETEST_PULSE |-> $past(rt); endproperty
	a_rt: assert property (p_rt) else $error("stray retest");
	property p_one; RETEST_PULSE |=> !RETEST_PULSE; endproperty
	a_one: assert property (p_one) else $error("long retest");
endmodule
bind spcc_top spcc_monitor u_mon(
	.CLK(CLK),
	.RST_N(RST_N),
	.PSEL(PSEL),
	.PENABLE(PENABLE),
	.PWRITE(PWRITE),
	.PADDR(PADDR),
	.PRDATA(PRDATA),
	.CARD_BUS_IDLE(CARD_BUS_IDLE),
	.CARD_CLOCK_STOP_REQ(CARD_CLOCK_STOP_REQ),
	.CARD_SUPPLY(CARD_SUPPLY),
	.PROGRAMMING_SUPPLY(PROGRAMMING_SUPPLY),
	.RETEST_PULSE(RETEST_PULSE)
);

// ### dv/spcc_tb_top.sv
// Bench for the socket control bank: APB writes, card voltages, stop policy.
// Assumes zero-wait APB and the card model on the pins.
`timescale 1ns/1ps
module spcc_tb_top
	import spcc_pkg::*;
;
	logic CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, quiet = 0;
	logic HOST_CLOCK_STOP_REQ = 0, FORCE_DISABLE = 0, CARD_BUS_IDLE;
	logic PREADY, PSLVERR, CARD_CLOCK_STOP_REQ, RETEST_PULSE;
	logic [11:0] PADDR = 0;
	logic [31:0] PWDATA = 0, PRDATA, rd;
	logic [3:0] CARD_ACCEPT_VOLTAGES, volts = 4'hF;
	logic [2:0] CARD_SUPPLY, PROGRAMMING_SUPPLY, ec = 0, ep = 0;
	logic slverr;
	int error_cnt = 0, total_checks = 0;
	spcc_top u_dut(
		.CLK(CLK),
		.RST_N(RST_N),
		.PSEL(PSEL),
		.PENABLE(PENABLE),
		.PWRITE(PWRITE),
		.PADDR(PADDR),
		.PWDATA(PWDATA),
		.PRDATA(PRDATA),
		.PREADY(PREADY),
		.PSLVERR(PSLVERR),
		.CARD_BUS_IDLE(CARD_BUS_IDLE),
		.HOST_CLOCK_STOP_REQ(HOST_CLOCK_STOP_REQ),
		.CARD_ACCEPT_VOLTAGES(CARD_ACCEPT_VOLTAGES),
		.FORCE_DISABLE(FORCE_DISABLE),
		.CARD_CLOCK_STOP_REQ(CARD_CLOCK_STOP_REQ),
		.CARD_SUPPLY(CARD_SUPPLY),
		.PROGRAMMING_SUPPLY(PROGRAMMING_SUPPLY),
		.RETEST_PULSE(RETEST_PULSE)
	);
	spcc_card u_card(.clk(CLK), .quiet(quiet), .volts(volts), .idle(CARD_BUS_IDLE),
		.acc(CARD_ACCEPT_VOLTAGES));
	initial forever #12.5 CLK = ~CLK;
	task automatic finish_test();
		if (error_cnt == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(logic [31:0] a, logic [31:0] e);
		total_checks++;
		if (a !== e)
		begin
			error_cnt++;
			$display("wrong value at %0t: %h expected %h", $time, a, e);
		end
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		slverr = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	function automatic logic [2:0] app(logic [2:0] c, p, logic [3:0] m, bit g);
		if (c == 3'h0 || (g && c == 3'h1))
			return c;
		if (c < 3'h2 || c > 3'h5 || !m[c - 3'h2])
			return p;
		return c;
	endfunction
	function automatic logic [31:0] sts(logic en);
		return {20'h00000, en, volts, ec, 1'b0, ep};
	endfunction
	task automatic wr(logic [7:0] d);
		apb(1'b1, 12'h010, {24'h0, d});
		ec = app(d[6:4], ec, volts, 1'b0);
		ep = app(d[2:0], ep, volts, 1'b1);
		repeat (2) @(posedge CLK);
		chk(CARD_SUPPLY, ec);
		chk(PROGRAMMING_SUPPLY, ep);
	endtask
	initial
	begin
		void'($urandom(32'h2655));
		repeat (5) @(posedge CLK);
		RST_N <= 1'b1;
		repeat (3) @(posedge CLK);
		apb(1'b0, 12'h010, 0);
		chk(rd, 0);
		apb(1'b1, 12'h010, 32'hFFFFFFFF);
		apb(1'b0, 12'h010, 0);
		chk(rd, 32'hF7);
		wr(8'h66);
		chk(slverr, 0);
		apb(1'b0, 12'h01C, 0);
		chk(rd, 0);
		chk(slverr, 1);
		for (int i = 0; i < 30; i++)
		begin
			volts <= 4'($urandom);
			repeat (8) @(posedge CLK);
			wr(8'($urandom) & 8'h77);
		end
		volts <= 4'hF;
		repeat (8) @(posedge CLK);
		wr(8'h00);
		FORCE_DISABLE <= 1'b1;
		@(posedge CLK);
		FORCE_DISABLE <= 1'b0;
		apb(1'b1, 12'h010, 32'h22);
		repeat (2) @(posedge CLK);
		chk(CARD_SUPPLY, ec);
		chk(PROGRAMMING_SUPPLY, ep);
		apb(1'b0, 12'h014, 0);
		chk(rd, sts(1'b0));
		apb(1'b1, 12'h018, 32'h4000);
		@(posedge CLK);
		chk(RETEST_PULSE, 1);
		wr(8'hA2);
		apb(1'b0, 12'h014, 0);
		chk(rd, sts(1'b1));
		quiet <= 1'b1;
		repeat (20) @(posedge CLK);
		chk(CARD_CLOCK_STOP_REQ, 1);
		wr(8'h22);
		repeat (20) @(posedge CLK);
		chk(CARD_CLOCK_STOP_REQ, 0);
		HOST_CLOCK_STOP_REQ <= 1'b1;
		repeat (8) @(posedge CLK);
		chk(CARD_CLOCK_STOP_REQ, 1);
		quiet <= 1'b0;
		repeat (20) @(posedge CLK);
		chk(CARD_CLOCK_STOP_REQ, 0);
		finish_test();
	end
	initial
	begin
		#100us;
		error_cnt++;
		finish_test();
	end
endmodule
